// file: design/tcc_chan.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// one timer's compare/capture channel set
// ------------------------------------------------------------
module tcc_chan #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic [W-1:0] counter_value,
    input  wire logic [W-1:0] cmp_a,
    input  wire logic [W-1:0] cmp_b,
    input  wire logic [W-1:0] cmp_c,
    input  wire logic         cap_src,
    input  wire logic         cap_rise,
    input  wire logic         cap_is_top,
    output logic [2:0]        match,
    output logic              cap_event,
    output logic [W-1:0]      capture_value_reg
);
    logic         src_d_ff;
    logic [W-1:0] cap_ff;
    wire          edge_hit;

    // selected edge; disabled while capture acts as top [RULE20]
    assign edge_hit = !cap_is_top &&
        (cap_rise ? (cap_src && !src_d_ff) : (!cap_src && src_d_ff));
    // continuous equality on every timer tick [RULE1]
    assign match = tick ? {counter_value == cmp_c,
                           counter_value == cmp_b,
                           counter_value == cmp_a} : 3'h0;
    assign cap_event = edge_hit;
    assign capture_value_reg = cap_ff;

    // latch counter on qualifying edge [RULE3]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_d_ff <= 1'b0;
            cap_ff   <= '0;
        end else begin
            src_d_ff <= cap_src;
            if (edge_hit)
                cap_ff <= counter_value;
        end
    end
endmodule

// file: design/tcc_pkg.sv
package tcc_pkg;
    // ------------------------------------------------------------
    // register map (byte-wide plain port, offsets chosen locally)
    // ------------------------------------------------------------
    localparam logic [4:0] A_T1_CMPA_L = 5'h00;
    localparam logic [4:0] A_T1_CMPA_H = 5'h01;
    localparam logic [4:0] A_T1_CMPB_L = 5'h02;
    localparam logic [4:0] A_T1_CMPB_H = 5'h03;
    localparam logic [4:0] A_T1_CMPC_L = 5'h04;
    localparam logic [4:0] A_T1_CMPC_H = 5'h05;
    localparam logic [4:0] A_T1_CAP_L  = 5'h06;
    localparam logic [4:0] A_T1_CAP_H  = 5'h07;
    localparam logic [4:0] A_T3_CMPA_L = 5'h08;
    localparam logic [4:0] A_T3_CMPA_H = 5'h09;
    localparam logic [4:0] A_T3_CMPB_L = 5'h0a;
    localparam logic [4:0] A_T3_CMPB_H = 5'h0b;
    localparam logic [4:0] A_T3_CMPC_L = 5'h0c;
    localparam logic [4:0] A_T3_CMPC_H = 5'h0d;
    localparam logic [4:0] A_T3_CAP_L  = 5'h0e;
    localparam logic [4:0] A_T3_CAP_H  = 5'h0f;
    localparam logic [4:0] A_MASK      = 5'h10;
    localparam logic [4:0] A_EXT_MASK  = 5'h11;
    localparam logic [4:0] A_FLAGS     = 5'h12;
    localparam logic [4:0] A_EXT_FLAGS = 5'h13;
    localparam logic [4:0] A_CTRL      = 5'h14;
    // ------------------------------------------------------------
    // bit positions shared by both mask and flag registers
    // ------------------------------------------------------------
    localparam int B_CAP  = 5;
    localparam int B_CMPA = 4;
    localparam int B_CMPB = 3;
    localparam int B_OVF  = 2;
    localparam int B_T3C  = 1;
    localparam int B_T1C  = 0;
    // main mask bits owned by this block
    localparam logic [7:0] MASK_OWN    = 8'h3c;
    localparam logic [7:0] EXT_MASK_WR = 8'h3f;
    // control register: t1 src, t1 top, t3 top, t1 edge, t3 edge
    localparam int C_T1_ACSEL = 0;
    localparam int C_T1_TOP   = 1;
    localparam int C_T3_TOP   = 2;
    localparam int C_T1_EDGE  = 3;
    localparam int C_T3_EDGE  = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

// file: design/tcc_sync.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// three-stage pin synchroniser, change taken when stages 1/2 agree
// ------------------------------------------------------------
module tcc_sync (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] sh_ff;
    logic       level_ff;

    // stage 0 feeds only stage 1; metastability stays out of logic
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sh_ff    <= 3'h0;
            level_ff <= 1'b0;
        end else begin
            sh_ff <= {sh_ff[1:0], pin};
            if (sh_ff[1] == sh_ff[2])
                level_ff <= sh_ff[2];
        end
    end

    assign level = level_ff;
endmodule

// file: design/tcc_top.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: compare registers matched to counter every tick
// RULE2: compare writes use shared high-byte latch
// RULE3: capture loads counter on pin or comparator
// RULE4: capture value can serve as counter top
// RULE5: low-byte capture read latches high byte
// RULE6: main mask bit5 gates t1 capture irq
// RULE7: main mask bit4 gates t1 compare A
// RULE8: main mask bit3 gates t1 compare B
// RULE9: main mask bit2 gates t1 overflow
// RULE10: software writes zero to ext mask 7:6
// RULE11: ext mask bit5 gates t3 capture
// RULE12: ext mask bit4 gates t3 compare A
// RULE13: ext mask bit3 gates t3 compare B
// RULE14: ext mask bit2 gates t3 overflow
// RULE15: ext mask bit1 gates t3 compare C
// RULE16: ext mask bit0 gates t1 compare C
// RULE17: legacy mode hides extended mask register
// RULE18: compare flag set tick after match only
// RULE19: flags clear on vector ack or write-one; t3 compare C flag (ext bit1) has no ack, ext_irq_ack[0] clears t1 compare C
// RULE20: capture as top disables capture pin
// RULE21: foreign main mask bits stored, never gate
module tcc_top
    import tcc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [4:0]   addr,
    input  wire logic [7:0]   wdata,
    input  wire logic         wr_stb,
    input  wire logic         rd_stb,
    output logic [7:0]        rdata,
    input  wire logic         t1_tick,
    input  wire logic [W-1:0] t1_counter_value,
    input  wire logic         t1_overflow,
    input  wire logic         t3_tick,
    input  wire logic [W-1:0] t3_counter_value,
    input  wire logic         t3_overflow,
    input  wire logic         t1_capture_input_pin,
    input  wire logic         t3_capture_input_pin,
    input  wire logic         acomp_out,
    input  wire logic         legacy_mode,
    input  wire logic         global_irq_en,
    input  wire logic [5:0]   irq_ack,
    input  wire logic [4:0]   ext_irq_ack,
    output logic [5:0]        t1_irq,
    output logic [4:0]        t3_irq,
    output logic [2:0]        t1_compare_match,
    output logic [2:0]        t3_compare_match,
    output logic              t1_top_is_capture,
    output logic              t3_top_is_capture,
    output logic [W-1:0]      t1_top_value,
    output logic [W-1:0]      t3_top_value
);
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sh_ff;
    wire        rst_n = rst_sh_ff[1];
    wire        t1_pin_s;
    wire        t3_pin_s;
    wire        ac_s;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            rst_sh_ff <= 2'h0;
        else
            rst_sh_ff <= {rst_sh_ff[0], 1'b1};
    end

    tcc_sync u_s1 (.clock(clock), .rst_b(rst_n),
                   .pin(t1_capture_input_pin), .level(t1_pin_s));
    tcc_sync u_s3 (.clock(clock), .rst_b(rst_n),
                   .pin(t3_capture_input_pin), .level(t3_pin_s));
    tcc_sync u_sa (.clock(clock), .rst_b(rst_n),
                   .pin(acomp_out), .level(ac_s));

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]   temp_ff;
    logic [W-1:0] t1_cmp_ff [3];
    logic [W-1:0] t3_cmp_ff [3];
    logic [7:0]   timer_irq_mask_ff;
    logic [5:0]   ext_timer_irq_mask_ff;
    logic [5:0]   timer_irq_flags_ff;
    logic [5:0]   ext_timer_irq_flags_ff;
    logic [4:0]   ctrl_ff;
    logic [7:0]   rdata_ff;
    logic [5:0]   t1_irq_ff;
    logic [4:0]   t3_irq_ff;
    logic [2:0]   t1_m_ff;
    logic [2:0]   t3_m_ff;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    wire [2:0]   t1_match;
    wire [2:0]   t3_match;
    wire         t1_cap_ev;
    wire         t3_cap_ev;
    wire [W-1:0] t1_cap;
    wire [W-1:0] t3_cap;
    wire         t1_src;

    // comparator may replace the pin for timer 1 only [RULE3]
    assign t1_src = ctrl_ff[C_T1_ACSEL] ? ac_s : t1_pin_s;

    tcc_chan #(.W(W)) u_c1 (
        .clock(clock), .rst_n(rst_n), .tick(t1_tick),
        .counter_value(t1_counter_value),
        .cmp_a(t1_cmp_ff[0]), .cmp_b(t1_cmp_ff[1]), .cmp_c(t1_cmp_ff[2]),
        .cap_src(t1_src), .cap_rise(ctrl_ff[C_T1_EDGE]),
        .cap_is_top(ctrl_ff[C_T1_TOP]),
        .match(t1_match), .cap_event(t1_cap_ev),
        .capture_value_reg(t1_cap));
    tcc_chan #(.W(W)) u_c3 (
        .clock(clock), .rst_n(rst_n), .tick(t3_tick),
        .counter_value(t3_counter_value),
        .cmp_a(t3_cmp_ff[0]), .cmp_b(t3_cmp_ff[1]), .cmp_c(t3_cmp_ff[2]),
        .cap_src(t3_pin_s), .cap_rise(ctrl_ff[C_T3_EDGE]),
        .cap_is_top(ctrl_ff[C_T3_TOP]),
        .match(t3_match), .cap_event(t3_cap_ev),
        .capture_value_reg(t3_cap));

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire ext_ok   = !legacy_mode;                          // [RULE17]
    wire wr_mask  = wr_stb && addr == A_MASK;
    wire wr_emask = wr_stb && addr == A_EXT_MASK && ext_ok;
    wire wr_flag  = wr_stb && addr == A_FLAGS;
    wire wr_eflag = wr_stb && addr == A_EXT_FLAGS && ext_ok;
    wire wr_ctrl  = wr_stb && addr == A_CTRL;
    wire wr_hi    = wr_stb && addr < A_MASK && addr[0];
    wire wr_cmp1  = wr_stb && !addr[0] && addr[4:3] == 2'h0
                    && addr[2:1] != 2'h3;
    wire wr_cmp3  = wr_stb && !addr[0] && addr[4:3] == 2'h1
                    && addr[2:1] != 2'h3;
    wire rd_cap_lo = rd_stb && (addr == A_T1_CAP_L || addr == A_T3_CAP_L);
    wire [1:0] ch  = addr[2:1];

    // top reaches counter only in capture-top mode [RULE4]
    wire t1_top_hit = ctrl_ff[C_T1_TOP] && t1_tick
                      && t1_counter_value == t1_cap;
    wire t3_top_hit = ctrl_ff[C_T3_TOP] && t3_tick
                      && t3_counter_value == t3_cap;

    // set sources in flag bit order: cap, a, b, ovf, t3c, t1c (t1 set has zeros in the last two)
    wire [5:0] t1_set = {t1_cap_ev || t1_top_hit, t1_m_ff[0], t1_m_ff[1],
                         t1_overflow, 2'h0};
    wire [5:0] t3_set = {t3_cap_ev || t3_top_hit, t3_m_ff[0], t3_m_ff[1],
                         t3_overflow, t3_m_ff[2], t1_m_ff[2]};

    // set beats write-one or ack in the same cycle [RULE19]
    wire [5:0] nxt_flags  = t1_set | (timer_irq_flags_ff &
                            ~((wr_flag ? wdata[5:0] : 6'h0) | irq_ack));
    wire [5:0] nxt_eflags = t3_set | (ext_timer_irq_flags_ff &
                            ~((wr_eflag ? wdata[5:0] : 6'h0)
                              | {ext_irq_ack[4:1], 1'b0, ext_irq_ack[0]}));

    function automatic logic [7:0] sel_byte(input logic [W-1:0] v,
                                            input logic hi);
        sel_byte = hi ? v[15:8] : v[7:0];
    endfunction

    function automatic logic [W-1:0] cap_of(input logic t3);
        cap_of = t3 ? t3_cap : t1_cap;
    endfunction

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (addr < A_MASK) begin
            if (addr[0])
                rd_mux = temp_ff;                   // high read via temp
            else if (ch == 2'h3)
                rd_mux = sel_byte(cap_of(addr[3]), 1'b0);
            else
                rd_mux = sel_byte(addr[3] ? t3_cmp_ff[ch] : t1_cmp_ff[ch],
                                  1'b0);
        end else begin
            case (addr)
                A_MASK:      rd_mux = timer_irq_mask_ff;      // [RULE21]
                A_EXT_MASK:  rd_mux = ext_ok ?
                                 {2'h0, ext_timer_irq_mask_ff} : 8'h00;
                A_FLAGS:     rd_mux = {2'h0, timer_irq_flags_ff};
                A_EXT_FLAGS: rd_mux = ext_ok ?
                                 {2'h0, ext_timer_irq_flags_ff} : 8'h00;
                A_CTRL:      rd_mux = {3'h0, ctrl_ff};
                default:     rd_mux = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // 16-bit access: temp latch shared by all wide registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            temp_ff <= RST_BYTE;
        end else if (wr_hi) begin
            temp_ff <= wdata;                                  // [RULE2]
        end else if (rd_cap_lo) begin
            temp_ff <= sel_byte(cap_of(addr[3]), 1'b1);        // [RULE5]
        end else if (rd_stb && addr < A_MASK && !addr[0]) begin
            temp_ff <= sel_byte(addr[3] ? t3_cmp_ff[ch] : t1_cmp_ff[ch],
                                1'b1);
        end
    end

    // low-byte write commits both bytes at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t1_cmp_ff <= '{default: RST_WORD};
            t3_cmp_ff <= '{default: RST_WORD};
        end else begin
            if (wr_cmp1)
                t1_cmp_ff[ch] <= {temp_ff, wdata};             // [RULE2]
            if (wr_cmp3)
                t3_cmp_ff[ch] <= {temp_ff, wdata};             // [RULE2]
        end
    end

    // masks, control; ext mask stores bits 5:0 only, top bits read zero [RULE10]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_mask_ff     <= RST_BYTE;
            ext_timer_irq_mask_ff <= 6'h00;
            ctrl_ff               <= 5'h00;
        end else begin
            if (wr_mask)
                timer_irq_mask_ff <= wdata;                    // [RULE21]
            if (wr_emask)
                ext_timer_irq_mask_ff <= wdata[5:0];
            if (wr_ctrl)
                ctrl_ff <= wdata[4:0];
        end
    end

    // match registered so flag rises the tick after equality [RULE18]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t1_m_ff                <= 3'h0;
            t3_m_ff                <= 3'h0;
            timer_irq_flags_ff     <= 6'h00;
            ext_timer_irq_flags_ff <= 6'h00;
        end else begin
            t1_m_ff                <= t1_match;
            t3_m_ff                <= t3_match;
            timer_irq_flags_ff     <= nxt_flags & {4'hf, 2'h0};
            ext_timer_irq_flags_ff <= nxt_eflags;
        end
    end

    // ------------------------------------------------------------
    // interrupt requests: mask and global enable and flag
    // ------------------------------------------------------------
    wire [5:0] emask = ext_ok ? ext_timer_irq_mask_ff : 6'h00;  // [RULE17]
    wire [5:0] nxt_t1_irq = {6{global_irq_en}} & {
        timer_irq_mask_ff[B_CAP]  & timer_irq_flags_ff[B_CAP],   // [RULE6]
        timer_irq_mask_ff[B_CMPA] & timer_irq_flags_ff[B_CMPA],  // [RULE7]
        timer_irq_mask_ff[B_CMPB] & timer_irq_flags_ff[B_CMPB],  // [RULE8]
        timer_irq_mask_ff[B_OVF]  & timer_irq_flags_ff[B_OVF],   // [RULE9]
        1'b0,
        emask[B_T1C] & ext_timer_irq_flags_ff[B_T1C]};           // [RULE16]
    wire [4:0] nxt_t3_irq = {5{global_irq_en}} & {
        emask[B_CAP]  & ext_timer_irq_flags_ff[B_CAP],           // [RULE11]
        emask[B_CMPA] & ext_timer_irq_flags_ff[B_CMPA],          // [RULE12]
        emask[B_CMPB] & ext_timer_irq_flags_ff[B_CMPB],          // [RULE13]
        emask[B_OVF]  & ext_timer_irq_flags_ff[B_OVF],           // [RULE14]
        emask[B_T3C]  & ext_timer_irq_flags_ff[B_T3C]};          // [RULE15]

    // outputs all registered; irq lags flag by one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff  <= 8'h00;
            t1_irq_ff <= 6'h00;
            t3_irq_ff <= 5'h00;
        end else begin
            rdata_ff  <= rd_stb ? rd_mux : 8'h00;
            t1_irq_ff <= nxt_t1_irq;
            t3_irq_ff <= nxt_t3_irq;
        end
    end

    assign rdata             = rdata_ff;
    assign t1_irq            = t1_irq_ff;
    assign t3_irq            = t3_irq_ff;
    assign t1_compare_match  = t1_m_ff;                         // [RULE1]
    assign t3_compare_match  = t3_m_ff;
    assign t1_top_is_capture = ctrl_ff[C_T1_TOP];               // [RULE4]
    assign t3_top_is_capture = ctrl_ff[C_T3_TOP];
    assign t1_top_value      = t1_cap;
    assign t3_top_value      = t3_cap;
endmodule

// file: testbench/tcc_checker.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// port-level checks for the compare/capture/mask block
// ------------------------------------------------------------
module tcc_checker
    import tcc_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic         clock,
    input wire logic         rst_b,
    input wire logic [4:0]   addr,
    input wire logic [7:0]   wdata,
    input wire logic         wr_stb,
    input wire logic         rd_stb,
    input wire logic [7:0]   rdata,
    input wire logic         t1_tick,
    input wire logic         legacy_mode,
    input wire logic         global_irq_en,
    input wire logic [5:0]   t1_irq,
    input wire logic [4:0]   t3_irq,
    input wire logic [2:0]   t1_compare_match,
    input wire logic         t1_top_is_capture,
    input wire logic         t3_top_is_capture,
    input wire logic [W-1:0] t1_top_value
);
    logic [7:0] msk_ff;
    logic [7:0] xmsk_ff;

    default clocking dck @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // mask shadows; irq may lag a write by an edge, so accept both
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            msk_ff  <= 8'h00;
            xmsk_ff <= 8'h00;
        end else begin
            if (wr_stb && addr == A_MASK)
                msk_ff <= wdata;
            if (wr_stb && addr == A_EXT_MASK && !legacy_mode)
                xmsk_ff <= wdata;
        end
    end

    a_t1_irq_gie: assert property (
        (|t1_irq) |-> $past(global_irq_en))
        else $error("t1 interrupt without global enable");
    a_t3_irq_gie: assert property (
        (|t3_irq) |-> $past(global_irq_en))
        else $error("t3 interrupt without global enable");
    a_main_mask_gate: assert property (
        (t1_irq[5:2] & ~($past(msk_ff[5:2]) | $past(msk_ff[5:2], 2)))
            == 4'h0)
        else $error("t1 interrupt with its enable clear");
    a_ext_mask_gate: assert property (
        ({t3_irq, t1_irq[0]} & ~($past(xmsk_ff[5:0])
            | $past(xmsk_ff[5:0], 2))) == 6'h00)
        else $error("interrupt with extended enable clear");
    a_match_on_tick: assert property (
        (|t1_compare_match) |-> $past(t1_tick))
        else $error("compare match without timer tick");
    a_match_one_cycle: assert property (
        (|t1_compare_match) |=> (t1_compare_match == 3'b000))
        else $error("compare match longer than one cycle");
    a_top_mode_write: assert property (
        $changed({t1_top_is_capture, t3_top_is_capture})
            |-> $past(wr_stb) && ($past(addr) == A_CTRL))
        else $error("top mode changed without control write");
    a_cap_frozen_top: assert property (
        $changed(t1_top_value) |-> !$past(t1_top_is_capture))
        else $error("capture taken while capture is top");
    a_legacy_reads_zero: assert property (
        $past(rd_stb && legacy_mode && addr == A_EXT_MASK)
            |-> (rdata == 8'h00))
        else $error("extended mask visible in legacy mode");
    a_rdata_idle: assert property (
        !$past(rd_stb) |-> (rdata == 8'h00))
        else $error("read data outside its cycle");
endmodule

bind tcc_top tcc_checker #(.W(W)) u_tcc_checker (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .t1_tick(t1_tick), .legacy_mode(legacy_mode),
    .global_irq_en(global_irq_en), .t1_irq(t1_irq), .t3_irq(t3_irq),
    .t1_compare_match(t1_compare_match),
    .t1_top_is_capture(t1_top_is_capture),
    .t3_top_is_capture(t3_top_is_capture), .t1_top_value(t1_top_value)
);

// file: testbench/tcc_cnt_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// counter core stand-in: loadable up-counter, one tick a cycle
// ------------------------------------------------------------
module tcc_cnt_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ld,
    input  wire logic [15:0] ld_val,
    output logic             tick,
    output logic [15:0]      count,
    output logic             ovf
);
    // tick every cycle keeps waits short; overflow pulses on wrap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick  <= 1'b0;
            count <= 16'h0000;
            ovf   <= 1'b0;
        end else begin
            tick  <= 1'b1;
            count <= ld ? ld_val : count + 16'h0001;
            ovf   <= !ld && (count == 16'hffff);
        end
    end
endmodule

// file: testbench/tcc_top_tb.sv
`timescale 1ns/100ps
module tcc_top_tb
    import tcc_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus, models and checks
    // ------------------------------------------------------------
    logic        clock, rst_b, wr_stb, rd_stb, t1_pin, t3_pin, acomp;
    logic        legacy, gie, ld1, ld3, tk1, tk3, ov1, ov3, top1, top3;
    logic [4:0]  addr, ext_ack, t3_irq;
    logic [5:0]  irq_ack, t1_irq;
    logic [7:0]  wdata, rdata, rv;
    logic [2:0]  m1, m3;
    logic [10:0] irqv;
    logic [15:0] ld_val, cnt1, cnt3, tv1, tv3, cap, base;
    int          error_cnt, samples_checked;
    localparam logic [4:0] cmp_ad [6] = '{A_T1_CMPA_L, A_T1_CMPB_L,
        A_T1_CMPC_L, A_T3_CMPA_L, A_T3_CMPB_L, A_T3_CMPC_L};
    localparam int bit_pos [6] = '{B_CMPA, B_CMPB, B_T1C, B_CMPA,
        B_CMPB, B_T3C};
    localparam int irq_pos [6] = '{4, 3, 0, 9, 8, 6};

    assign irqv = {t3_irq, t1_irq};
    tcc_top #(.W(16)) u_tcc_top (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .t1_tick(tk1), .t1_counter_value(cnt1), .t1_overflow(ov1),
        .t3_tick(tk3), .t3_counter_value(cnt3), .t3_overflow(ov3),
        .t1_capture_input_pin(t1_pin), .t3_capture_input_pin(t3_pin),
        .acomp_out(acomp), .legacy_mode(legacy), .global_irq_en(gie),
        .irq_ack(irq_ack), .ext_irq_ack(ext_ack), .t1_irq(t1_irq),
        .t3_irq(t3_irq), .t1_compare_match(m1), .t3_compare_match(m3),
        .t1_top_is_capture(top1), .t3_top_is_capture(top3),
        .t1_top_value(tv1), .t3_top_value(tv3)
    );
    tcc_cnt_model u_cnt1 (.clock(clock), .rst_n(rst_b), .ld(ld1),
        .ld_val(ld_val), .tick(tk1), .count(cnt1), .ovf(ov1));
    tcc_cnt_model u_cnt3 (.clock(clock), .rst_n(rst_b), .ld(ld3),
        .ld_val(ld_val), .tick(tk3), .count(cnt3), .ovf(ov3));

    // free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    // strobe one cycle, data sampled mid-cycle, return on a rising edge
    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        rv = rdata;
        @(posedge clock);
    endtask

    // high byte goes first into the shared latch, low byte commits
    task automatic w16(input logic [4:0] a, input logic [15:0] v);
        wr(a | 5'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask

    // low byte first so the high byte is frozen with it
    task automatic rd16(input logic [4:0] a);
        rd(a);
        cap[7:0] = rv;
        rd(a | 5'h01);
        cap[15:8] = rv;
    endtask

    task automatic wait_irq(input int i);
        int n;
        n = 0;
        while (irqv[i] !== 1'b1 && n < 64) begin
            @(posedge clock);
            n++;
        end
        chk(irqv[i], 1'b1);
    endtask

    task automatic load(input logic [15:0] v);
        ld_val <= v;
        ld1    <= 1'b1;
        ld3    <= 1'b1;
        @(posedge clock);
        ld1    <= 1'b0;
        ld3    <= 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        test_done();
    end

    // main sequence
    initial begin
        {rst_b, wr_stb, rd_stb, t1_pin, acomp, legacy, gie} = '0;
        {ld1, ld3, addr, wdata, irq_ack, ext_ack, ld_val} = '0;
        t3_pin = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        rd16(A_T3_CMPA_L);
        chk(cap, 16'h0000);
        wr(A_T3_CMPA_H, 8'h5a);
        wr(A_T1_CMPB_L, 8'hc3);
        rd16(A_T1_CMPB_L);
        chk(cap, 16'h5ac3);
        for (int i = 0; i < 6; i++) begin
            base = 16'h1000 + 16'(i) * 16'h0100;
            w16(cmp_ad[i], base);
            rd16(cmp_ad[i]);
            chk(cap, base);
            load(base - 16'h0010);
            repeat (24) @(posedge clock);
            rd((i < 2) ? A_FLAGS : A_EXT_FLAGS);
            chk(rv[bit_pos[i]], 1'b1);
            wr((i < 2) ? A_MASK : A_EXT_MASK, 8'h01 << bit_pos[i]);
            repeat (3) @(posedge clock);
            chk(irqv, 16'h0000);
            gie <= 1'b1;
            wait_irq(irq_pos[i]);
            wr((i < 2) ? A_FLAGS : A_EXT_FLAGS, 8'h01 << bit_pos[i]);
            gie <= 1'b0;
            rd((i < 2) ? A_FLAGS : A_EXT_FLAGS);
            chk(rv[bit_pos[i]], 1'b0);
            chk(irqv[irq_pos[i]], 1'b0);
            wr((i < 2) ? A_MASK : A_EXT_MASK, 8'h00);
        end
        load(16'hfff0);
        wr(A_MASK, 8'h04);
        wr(A_EXT_MASK, 8'h04);
        gie <= 1'b1;
        wait_irq(2);
        wait_irq(7);
        irq_ack <= 6'h04;
        ext_ack <= 5'h02;
        @(posedge clock);
        irq_ack <= 6'h00;
        ext_ack <= 5'h00;
        repeat (3) @(posedge clock);
        chk(irqv, 16'h0000);
        wr(A_CTRL, 8'h08);
        wr(A_MASK, 8'h20);
        wr(A_EXT_MASK, 8'h20);
        base = cnt1;
        t1_pin <= 1'b1;
        t3_pin <= 1'b0;
        wait_irq(5);
        wait_irq(10);
        rd16(A_T1_CAP_L);
        chk((cap - base) < 16'h000c, 1'b1);
        wr(A_MASK, 8'hc3);
        repeat (3) @(posedge clock);
        chk(irqv[5], 1'b0);
        rd(A_MASK);
        chk(rv, 8'hc3);
        wr(A_FLAGS, 8'h20);
        wr(A_MASK, 8'h20);
        wr(A_CTRL, 8'h09);
        repeat (8) @(posedge clock);
        wr(A_FLAGS, 8'h20);
        base = cnt1;
        acomp <= 1'b1;
        wait_irq(5);
        rd16(A_T1_CAP_L);
        chk((cap - base) < 16'h000c, 1'b1);
        wr(A_CTRL, 8'h0b);
        @(posedge clock);
        chk(top1, 1'b1);
        chk(tv1, cap);
        acomp <= 1'b0;
        repeat (8) @(posedge clock);
        acomp <= 1'b1;
        repeat (12) @(posedge clock);
        chk(tv1, cap);
        gie <= 1'b0;
        legacy <= 1'b1;
        wr(A_EXT_MASK, 8'h3f);
        rd(A_EXT_MASK);
        chk(rv, 8'h00);
        legacy <= 1'b0;
        rd(A_EXT_MASK);
        chk(rv, 8'h20);
        rd(5'h1f);
        chk(rv, 8'h00);
        test_done();
    end
endmodule
